//--- logic/cmc_pkg.sv
/*
  Shared constants for the configurable macrocell logic block: sizes,
  select encodings and reset values.
  Assumes it is compiled before every other file of the block.
*/
package cmc_pkg;

  // Array figures
  localparam int PT_PER_MC    = 5;
  localparam int MC_PER_BLOCK = 16;
  localparam int MATRIX_W     = 40;
  localparam int TOTAL_MC     = 128;
  localparam int NUM_CHAINS   = 8;
  localparam int DED_N        = 4;
  localparam int GOE_N        = 6;
  localparam int GBUS_W       = 228;
  localparam int SIG_W        = 16;
  localparam int MAX_CASC_PT  = 40;
  localparam int MAX_FOLD_PT  = 21;

  // Field widths of per-macrocell selects
  localparam int PT_IDX_W = 3;
  localparam int SEL2_W   = 2;
  localparam int OE_SEL_W = 3;

  // Storage element modes
  typedef enum logic [2:0] {
    CMC_MODE_D,
    CMC_MODE_T,
    CMC_MODE_JK,
    CMC_MODE_SR,
    CMC_MODE_LATCH
  } cmc_mode_e;

  // Second XOR operand
  localparam logic [1:0] XS_PT   = 2'h0;
  localparam logic [1:0] XS_HIGH = 2'h1;
  localparam logic [1:0] XS_LOW  = 2'h2;
  localparam logic [1:0] XS_Q    = 2'h3;

  // Storage data source
  localparam logic [1:0] DS_XOR = 2'h0;
  localparam logic [1:0] DS_PT  = 2'h1;
  localparam logic [1:0] DS_PIN = 2'h2;

  // Asynchronous clear source
  localparam logic [1:0] CS_NONE   = 2'h0;
  localparam logic [1:0] CS_GLOBAL = 2'h1;
  localparam logic [1:0] CS_PT     = 2'h2;
  localparam logic [1:0] CS_BOTH   = 2'h3;

  // Output enable select: 0..5 pick a global line
  localparam logic [2:0] OE_ALWAYS_ON  = 3'h6;
  localparam logic [2:0] OE_ALWAYS_OFF = 3'h7;

  // Reset values
  localparam logic [15:0] SIG_RESET   = 16'h0000;
  localparam logic        STATE_RESET = 1'h0;

endpackage

//--- logic/cmc_pterm.sv
/*
  One product term: AND of true and complemented literals taken from the
  switch matrix and the regional foldback bus, plus the matrix-only part.
  Assumes mask bits are held steady by the configuration store.
*/
`timescale 1ns/1ns
module cmc_pterm #(
  parameter int MX_W = 40,
  parameter int RB_W = 16
) (
  input  wire logic [MX_W-1:0]          matrix_i,
  input  wire logic [RB_W-1:0]          region_i,
  input  wire logic [2*(MX_W+RB_W)-1:0] mask_i,
  output logic                          term_o,
  output logic                          matrix_term_o
);
  localparam int IN_W = MX_W + RB_W;

  logic [IN_W-1:0] lits;
  logic [IN_W-1:0] use_true;
  logic [IN_W-1:0] use_comp;
  logic [IN_W-1:0] ok;

  assign lits     = {region_i, matrix_i};
  assign use_true = mask_i[IN_W-1:0];
  assign use_comp = mask_i[2*IN_W-1:IN_W];
  // Both literals of one input set gives a term stuck low, as in a real array
  assign ok       = (~use_true | lits) & (~use_comp | ~lits);

  assign term_o        = &ok;
  // Foldback source: matrix inputs only, so no path loops through the bus
  assign matrix_term_o = &ok[MX_W-1:0];
endmodule

//--- logic/cmc_store.sv
/*
  Storage element of one macrocell: D, T, JK, SR or transparent latch,
  emulated on the system clock with asynchronous clear and preset.
  Assumes the selected clock level is synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
module cmc_store
  import cmc_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      rst_i,
  input  wire cmc_mode_e mode_i,
  input  wire logic      d_i,
  input  wire logic      aux_i,
  input  wire logic      ck_i,
  input  wire logic      ce_i,
  input  wire logic      clr_i,
  input  wire logic      pre_i,
  output logic           q_o,
  output logic           state_o
);
  logic ck_prev;
  logic state;
  logic next_state;
  logic rise;

  assign rise = ck_i & ~ck_prev;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ck_prev <= 1'b0;
    end else begin
      ck_prev <= ck_i;
    end
  end

  always_comb begin
    next_state = state;
    case (mode_i)
      CMC_MODE_D:     next_state = d_i;
      CMC_MODE_T:     next_state = d_i ? ~state : state;
      CMC_MODE_JK:    next_state = (d_i & ~state) | (~aux_i & state);
      CMC_MODE_SR:    next_state = (d_i & ~aux_i) | (state & ~(aux_i & ~d_i));
      CMC_MODE_LATCH: next_state = ck_i ? d_i : state;
      default:        next_state = state;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= STATE_RESET;
    end else if (clr_i) begin
      state <= 1'b0;
    end else if (pre_i) begin
      state <= 1'b1;
    end else if (mode_i == CMC_MODE_LATCH) begin
      state <= next_state;
    end else if (rise && ce_i) begin
      state <= next_state;
    end
  end

  // Clear and preset act at once, not at the next edge
  always_comb begin
    if (clr_i) begin
      q_o = 1'b0;
    end else if (pre_i) begin
      q_o = 1'b1;
    end else if (mode_i == CMC_MODE_LATCH && ck_i) begin
      q_o = d_i;
    end else begin
      q_o = state;
    end
  end

  assign state_o = state;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet_edge;
    rise && !clr_i && !pre_i && mode_i != CMC_MODE_LATCH;
  endsequence

  a_clear_wins: assert property ((clr_i && pre_i) |-> (q_o == 1'b0) ##1 (state == 1'b0))
    else $error("clear did not win over preset");
  a_preset_sets: assert property ((pre_i && !clr_i) |=> state)
    else $error("preset did not set the element");
  a_d_capture: assert property ((s_quiet_edge and (ce_i && mode_i == CMC_MODE_D))
    |=> state == $past(d_i))
    else $error("D element missed a rising edge");
  a_ce_blocks: assert property ((s_quiet_edge and !ce_i) |=> $stable(state))
    else $error("disabled edge changed the element");
  a_no_fall: assert property ((!rise && !clr_i && !pre_i && mode_i != CMC_MODE_LATCH)
    |=> $stable(state))
    else $error("element changed without a rising edge");
  a_toggle: assert property ((s_quiet_edge and (ce_i && d_i && mode_i == CMC_MODE_T))
    |=> state != $past(state))
    else $error("T element did not toggle");
  a_latch_pass: assert property ((mode_i == CMC_MODE_LATCH && ck_i && !clr_i && !pre_i)
    |-> q_o == d_i)
    else $error("latch not transparent while clock high");
  a_latch_hold: assert property ((mode_i == CMC_MODE_LATCH && !ck_i && !clr_i && !pre_i)[*2]
    |-> $stable(q_o))
    else $error("latch output moved while clock low");
endmodule

//--- logic/cmc_block.sv
/*
  One logic block of the programmable array: switch matrix, sixteen
  macrocells with product terms, OR/XOR/cascade logic, storage, output and
  enable selection, regional foldback bus and the user signature.
  Assumes every configuration input is held steady while the block runs
  and that pins are sampled synchronously to clk_sys_i.
*/
// What this block does
// - Each macrocell has five product terms fed by global and regional buses.
// - A selector sends each product term to the sum or a control signal.
// - OR sums up to five local terms; cascade extends to forty terms.
// - XOR takes the sum and a term, constant high or constant low.
// - XOR with the stored value emulates T and JK ahead of a D element.
// - Storage data comes from XOR output, a separate term or the pin.
// - Separate-term data gives buried registered feedback with combinational pin.
// - Storage works as D, T, JK, SR or a flow-through latch.
// - Latch passes data while clock high and holds while clock low.
// - Clock is global line or a product term; update on rising edge only.
// - With global clock, an enable term low makes rising edges ignored.
// - Clear is global, a term, their OR, or never active.
// - Preset is a product term or never active.
// - Pin and feedback each pick registered or combinational independently.
// - Output enable is always on, always off or one of six global enables.
// - A disabled pin still leaves feedback, foldback and cascade usable.
// - Switch matrix picks forty signals from the whole global bus.
// - Each macrocell drives an inverted product term onto the regional bus.
// - Regional foldback terms allow sums of up to twenty-one terms.
// - Eight cascade chains exist, each reaching forty product terms.
// - Each dedicated input can serve as clock, clear or output enable.
// - A sixteen-bit user signature stays readable whatever the protection.
`timescale 1ns/1ns
module cmc_block
  import cmc_pkg::*;
#(
  parameter int NUM_MC  = MC_PER_BLOCK,
  parameter int NUM_PT  = PT_PER_MC,
  parameter int MX_W    = MATRIX_W,
  parameter int BUS_W   = GBUS_W,
  parameter int IDX_W   = $clog2(GBUS_W),
  parameter int PT_IN_W = MATRIX_W + MC_PER_BLOCK
) (
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_i,
  input  wire logic [BUS_W-1:0]                 global_bus_i,
  input  wire logic [MX_W*IDX_W-1:0]            matrix_sel_i,
  input  wire logic [DED_N-1:0]                 ded_in_i,
  input  wire logic [GOE_N-1:0]                 goe_i,
  input  wire logic [GOE_N-1:0]                 goe_from_ded_i,
  input  wire logic [NUM_MC*NUM_PT*2*PT_IN_W-1:0] pt_mask_i,
  input  wire logic [NUM_MC*NUM_PT-1:0]         term_allocation_selector_i,
  input  wire logic [NUM_MC*SEL2_W-1:0]         xor_sel_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       xor_pt_i,
  input  wire logic [NUM_MC*SEL2_W-1:0]         data_sel_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       data_pt_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       aux_pt_i,
  input  wire logic [NUM_MC*3-1:0]              store_mode_i,
  input  wire logic [NUM_MC-1:0]                clk_from_pt_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       clk_pt_i,
  input  wire logic [NUM_MC*SEL2_W-1:0]         gclk_idx_i,
  input  wire logic [NUM_MC-1:0]                ce_en_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       ce_pt_i,
  input  wire logic [NUM_MC*SEL2_W-1:0]         clr_mode_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       clr_pt_i,
  input  wire logic [NUM_MC*SEL2_W-1:0]         gclr_idx_i,
  input  wire logic [NUM_MC-1:0]                pre_en_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       pre_pt_i,
  input  wire logic [NUM_MC-1:0]                out_reg_i,
  input  wire logic [NUM_MC-1:0]                fb_reg_i,
  input  wire logic [NUM_MC*OE_SEL_W-1:0]       output_enable_selector_i,
  input  wire logic [NUM_MC-1:0]                cascade_en_i,
  input  wire logic [NUM_MC*PT_IDX_W-1:0]       fold_pt_i,
  input  wire logic                             cascade_in_i,
  input  wire logic [NUM_MC-1:0]                pin_i,
  input  wire logic                             sig_wr_i,
  input  wire logic [SIG_W-1:0]                 sig_data_i,
  output logic [NUM_MC-1:0]                     pin_o,
  output logic [NUM_MC-1:0]                     pin_oe_o,
  output logic [NUM_MC-1:0]                     feedback_o,
  output logic [NUM_MC-1:0]                     foldback_o,
  output logic                                  cascade_out_o,
  output logic [SIG_W-1:0]                      user_signature_o
);

  // Picks one of the macrocell's terms; an index past the last term reads low
  function automatic logic pick(input logic [NUM_PT-1:0] v, input logic [PT_IDX_W-1:0] idx);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_PT; i++) begin
      if (idx == PT_IDX_W'(i)) begin
        r = v[i];
      end
    end
    return r;
  endfunction

  logic [MX_W-1:0]   matrix;
  logic [NUM_MC-1:0] region;
  logic [NUM_MC:0]   casc;
  logic [GOE_N-1:0]  goe_line;
  logic [SIG_W-1:0]  signature;

  // Switch matrix: each of the forty lines names any global bus signal
  for (genvar s = 0; s < MX_W; s++) begin : g_mx
    logic [IDX_W-1:0] sel;
    assign sel = matrix_sel_i[s*IDX_W +: IDX_W];
    assign matrix[s] = (int'(sel) < BUS_W) ? global_bus_i[sel] : 1'b0;
    a_matrix_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (int'(sel) >= BUS_W) |-> !matrix[s])
      else $error("out-of-range matrix index not low");
  end

  // Global enable lines; dedicated inputs may stand in for them
  for (genvar g = 0; g < GOE_N; g++) begin : g_goe
    assign goe_line[g] = goe_from_ded_i[g] ? ded_in_i[g % DED_N] : goe_i[g];
  end

  assign region = foldback_o;
  // One block is one chain; eight blocks give the eight chains of the array
  assign casc[0]       = cascade_in_i;
  assign cascade_out_o = casc[NUM_MC];

  for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
    logic [NUM_PT-1:0]   pt;
    logic [NUM_PT-1:0]   pt_mx;
    logic [NUM_PT-1:0]   to_sum;
    logic [SEL2_W-1:0]   xsel;
    logic [SEL2_W-1:0]   dsel;
    logic [SEL2_W-1:0]   csel;
    logic [OE_SEL_W-1:0] oesel;
    logic                local_or;
    logic                sum;
    logic                xor_b;
    logic                xor_out;
    logic                d;
    logic                aux;
    logic                ck;
    logic                ce;
    logic                clr;
    logic                pre;
    logic                gclk_line;
    logic                global_clock_line;
    logic                global_clear_line;
    logic                async_clear;
    logic                async_preset;
    logic                q;
    logic                state;
    logic                oe;

    for (genvar p = 0; p < NUM_PT; p++) begin : g_pt
      localparam int BASE = (m * NUM_PT + p) * 2 * PT_IN_W;
      cmc_pterm #(
        .MX_W (MX_W),
        .RB_W (NUM_MC)
      ) u_pterm (
        .matrix_i      (matrix),
        .region_i      (region),
        .mask_i        (pt_mask_i[BASE +: 2*PT_IN_W]),
        .term_o        (pt[p]),
        .matrix_term_o (pt_mx[p])
      );
    end

    assign to_sum = term_allocation_selector_i[m*NUM_PT +: NUM_PT];
    assign xsel   = xor_sel_i[m*SEL2_W +: SEL2_W];
    assign dsel   = data_sel_i[m*SEL2_W +: SEL2_W];
    assign csel   = clr_mode_i[m*SEL2_W +: SEL2_W];
    assign oesel  = output_enable_selector_i[m*OE_SEL_W +: OE_SEL_W];

    // Terms given to control signals are kept out of the sum
    assign local_or = |(pt & to_sum);
    assign sum      = local_or | (cascade_en_i[m] & casc[m]);
    assign casc[m+1] = sum;

    // Foldback reaches every macrocell of the region: 5 local + 16 = 21 terms
    assign foldback_o[m] = ~pick(pt_mx, fold_pt_i[m*PT_IDX_W +: PT_IDX_W]);

    // Stored value is taken before the latch path, so no loop forms
    always_comb begin
      case (xsel)
        XS_PT:   xor_b = pick(pt, xor_pt_i[m*PT_IDX_W +: PT_IDX_W]);
        XS_HIGH: xor_b = 1'b1;
        XS_LOW:  xor_b = 1'b0;
        XS_Q:    xor_b = state;
        default: xor_b = 1'b0;
      endcase
    end
    assign xor_out = sum ^ xor_b;

    // Pin data in latch mode with the pin enabled loops through the pad; keep apart
    always_comb begin
      case (dsel)
        DS_XOR:  d = xor_out;
        DS_PT:   d = pick(pt, data_pt_i[m*PT_IDX_W +: PT_IDX_W]);
        DS_PIN:  d = pin_i[m];
        default: d = xor_out;
      endcase
    end
    assign aux = pick(pt, aux_pt_i[m*PT_IDX_W +: PT_IDX_W]);

    assign gclk_line = ded_in_i[gclk_idx_i[m*SEL2_W +: SEL2_W]];
    assign global_clock_line = gclk_line;
    assign global_clear_line = ded_in_i[gclr_idx_i[m*SEL2_W +: SEL2_W]];
    assign ck = clk_from_pt_i[m] ? pick(pt, clk_pt_i[m*PT_IDX_W +: PT_IDX_W])
                                 : global_clock_line;
    // Enable term only applies on the global clock
    assign ce = (ce_en_i[m] && !clk_from_pt_i[m]) ?
                pick(pt, ce_pt_i[m*PT_IDX_W +: PT_IDX_W]) : 1'b1;

    always_comb begin
      case (csel)
        CS_NONE:   async_clear = 1'b0;
        CS_GLOBAL: async_clear = global_clear_line;
        CS_PT:     async_clear = pick(pt, clr_pt_i[m*PT_IDX_W +: PT_IDX_W]);
        CS_BOTH:   async_clear = global_clear_line |
                                 pick(pt, clr_pt_i[m*PT_IDX_W +: PT_IDX_W]);
        default:   async_clear = 1'b0;
      endcase
    end
    assign async_preset = pre_en_i[m] & pick(pt, pre_pt_i[m*PT_IDX_W +: PT_IDX_W]);
    assign clr = async_clear;
    assign pre = async_preset;

    cmc_store u_store (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .mode_i    (cmc_mode_e'(store_mode_i[m*3 +: 3])),
      .d_i       (d),
      .aux_i     (aux),
      .ck_i      (ck),
      .ce_i      (ce),
      .clr_i     (clr),
      .pre_i     (pre),
      .q_o       (q),
      .state_o   (state)
    );

    // Combinational modes must follow the array, so these cannot be registered
    assign pin_o[m]      = out_reg_i[m] ? q : xor_out;
    assign feedback_o[m] = fb_reg_i[m] ? q : xor_out;

    always_comb begin
      case (oesel)
        OE_ALWAYS_ON:  oe = 1'b1;
        OE_ALWAYS_OFF: oe = 1'b0;
        default:       oe = (int'(oesel) < GOE_N) ? goe_line[oesel] : 1'b0;
      endcase
    end
    assign pin_oe_o[m] = oe;

    a_pin_path: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!out_reg_i[m] && fb_reg_i[m]) |-> (pin_o[m] == xor_out && feedback_o[m] == q))
      else $error("pin and feedback selects not independent");
    a_oe_off_fb: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (oesel == OE_ALWAYS_OFF) |-> (!pin_oe_o[m] && feedback_o[m] == (fb_reg_i[m] ? q : xor_out)))
      else $error("disabled pin lost feedback");
    a_cascade: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cascade_en_i[m] && casc[m]) |-> casc[m+1])
      else $error("cascade input not summed");
    a_xor_invert: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (xsel == XS_HIGH) |-> (xor_out == !sum))
      else $error("XOR high constant did not invert the sum");
    a_xor_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (xsel == XS_LOW) |-> (xor_out == sum))
      else $error("XOR low constant changed the sum");
    a_data_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (dsel == DS_PIN) |-> (d == pin_i[m]))
      else $error("pin data not routed to storage");
    a_clear_none: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (csel == CS_NONE) |-> !clr)
      else $error("clear active while disabled");
    a_clear_global: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (csel == CS_GLOBAL) |-> (clr == global_clear_line))
      else $error("global clear not followed");
    a_ce_term_clock: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      clk_from_pt_i[m] |-> ce)
      else $error("enable applied to a term clock");
    a_oe_always: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (oesel == OE_ALWAYS_ON) |-> pin_oe_o[m])
      else $error("always-on enable not driven");
    a_preset_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !pre_en_i[m] |-> !pre)
      else $error("preset active while disabled");
    a_fold_unused: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (fold_pt_i[m*PT_IDX_W +: PT_IDX_W] > 3'h4) |-> foldback_o[m])
      else $error("foldback of an empty index not high");
  end

  // Signature is kept apart from configuration readout, so protection never hides it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      signature <= SIG_RESET;
    end else if (sig_wr_i) begin
      signature <= sig_data_i;
    end
  end
  assign user_signature_o = signature;

  a_sig_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sig_wr_i ##1 !sig_wr_i |=> user_signature_o == $past(sig_data_i, 2))
    else $error("signature not held after load");
  a_sig_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !sig_wr_i |=> $stable(user_signature_o))
    else $error("signature changed without a write");

endmodule

//--- sim/cmc_pin_model.sv
/*
  Far side of the macrocell pins: external logic that drives or samples them.
  Assumes the bench says per pin whether the outside drives it; a pin that
  nobody drives shows a pattern that changes every cycle.
*/
`timescale 1ns/1ns
module cmc_pin_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe_o,
  input  wire logic [15:0] ext_val_i,
  input  wire logic [15:0] ext_drv_i,
  output logic      [15:0] pin_i
);
  logic [15:0] noise = 16'h5A5A;

  // Floating pins must not look like a steady last value
  always @(posedge clk_sys_i) begin
    noise <= ~noise;
  end

  // Wire level: the device wins while it drives, otherwise the outside or noise
  always_comb begin
    pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_drv_i & ext_val_i)
          | (~pin_oe_o & ~ext_drv_i & noise);
  end
endmodule

//--- sim/tb_configurable_logic_macrocell.sv
/*
  Self-checking bench for one logic block: signature, sum/XOR paths, output
  enable, storage with clock enable, clear and preset.
  Assumes the pin model stands on the pins; checks sample at falling edges.
*/
`timescale 1ns/1ns
module tb_configurable_logic_macrocell;
  import cmc_pkg::*;
  localparam int NM = MC_PER_BLOCK;
  logic                  clk_sys_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic [GBUS_W-1:0]     gbus = '0;
  logic [MATRIX_W*8-1:0] msel = '0;
  logic [DED_N-1:0]      ded = '0;
  logic [GOE_N-1:0]      goe = '0;
  logic [GOE_N-1:0]      gfd = '0;
  logic [NM*5*112-1:0]   mask = '0;
  logic [NM*5-1:0]       alloc = '0;
  logic [NM*2-1:0]       xs = '0;
  logic [NM*2-1:0]       dsel = {28'h0000000, 2'h2, 2'h0};
  logic [NM*2-1:0]       clrm = '0;
  logic [NM*2-1:0]       gclr = '0;
  logic [NM*2-1:0]       z2 = '0;
  logic [NM*3-1:0]       z3 = '0;
  logic [NM*3-1:0]       cept = '0;
  logic [NM*3-1:0]       prept = '0;
  logic [NM*3-1:0]       oesel;
  logic [NM*3-1:0]       smode = '0;
  logic [NM-1:0]         ceen = '0;
  logic [NM-1:0]         preen = '0;
  logic [NM-1:0]         oreg = '0;
  logic [NM-1:0]         freg = 16'h0002;
  // Upper cells cascade so the chain end shows the sum of cell 0
  logic [NM-1:0]         casen = 16'hFFFE;
  logic                  cin = 1'b0;
  logic                  cout;
  logic                  sig_wr = 1'b0;
  logic [15:0]           sig_d = '0;
  logic [15:0]           ext_val = '0;
  logic [NM-1:0]         pin_i, pin_o, pin_oe, fb, fold;
  logic [15:0]           sig;
  logic                  exp_b;
  int                    bad_count = 0;
  int                    n_compared = 0;
  int                    seed;

  cmc_block i_cmc_block (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .global_bus_i(gbus), .matrix_sel_i(msel),
    .ded_in_i(ded), .goe_i(goe), .goe_from_ded_i(gfd), .pt_mask_i(mask),
    .term_allocation_selector_i(alloc), .xor_sel_i(xs), .xor_pt_i(z3), .data_sel_i(dsel),
    .data_pt_i(z3), .aux_pt_i(z3), .store_mode_i(smode), .clk_from_pt_i(z2[NM-1:0]),
    .clk_pt_i(z3), .gclk_idx_i(z2), .ce_en_i(ceen), .ce_pt_i(cept), .clr_mode_i(clrm),
    .clr_pt_i(z3), .gclr_idx_i(gclr), .pre_en_i(preen), .pre_pt_i(prept),
    .out_reg_i(oreg), .fb_reg_i(freg), .output_enable_selector_i(oesel),
    .cascade_en_i(casen), .fold_pt_i(z3), .cascade_in_i(cin), .pin_i(pin_i),
    .sig_wr_i(sig_wr), .sig_data_i(sig_d), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .feedback_o(fb), .foldback_o(fold), .cascade_out_o(cout), .user_signature_o(sig));

  cmc_pin_model i_cmc_pin_model (
    .clk_sys_i(clk_sys_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .ext_val_i(ext_val),
    .ext_drv_i(16'hFFFF), .pin_i(pin_i));

  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic exp_sum(input logic al, input logic g, input logic ce,
                                   input logic ci, input logic hi);
    return ((al & g) | (ce & ci)) ^ hi;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Clock line rises for one sample, then returns low so the next rise is seen
  task automatic pulse();
    @(posedge clk_sys_i);
    ded[0] <= 1'b1;
    @(posedge clk_sys_i);
    ded[0] <= 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end

  initial begin
    oesel = {NM{3'h6}};
    oesel[5:3] = OE_ALWAYS_OFF;
    mask[0] = 1'b1;
    mask[113] = 1'b1;
    for (int s = 0; s < MATRIX_W; s++) msel[s*8 +: 8] = s[7:0];
    seed = $urandom(64267);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    check("sig_reset", sig, SIG_RESET);
    @(posedge clk_sys_i);
    sig_wr <= 1'b1;
    sig_d <= 16'($urandom);
    @(posedge clk_sys_i);
    sig_wr <= 1'b0;
    @(negedge clk_sys_i);
    check("sig_write", sig, sig_d);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys_i);
      gbus <= GBUS_W'({$urandom, $urandom, $urandom, $urandom,
                       $urandom, $urandom, $urandom, $urandom});
      cin <= 1'($urandom);
      alloc[0] <= 1'($urandom);
      casen[0] <= i[0];
      xs[1:0] <= i[1] ? XS_HIGH : XS_LOW;
      @(negedge clk_sys_i);
      exp_b = exp_sum(alloc[0], gbus[0], casen[0], cin, xs[1:0] == XS_HIGH);
      check("pin_comb", pin_o[0], exp_b);
      check("fb_comb", fb[0], exp_b);
      check("foldback", fold[0], !gbus[0]);
      check("cascade_out", cout, exp_sum(alloc[0], gbus[0], casen[0], cin, 1'b0));
    end
    for (int g = 0; g < 8; g++) begin
      @(posedge clk_sys_i);
      oesel[2:0] <= 3'(g);
      goe <= 6'($urandom);
      gfd <= 6'($urandom);
      ded <= 4'($urandom);
      @(negedge clk_sys_i);
      exp_b = (g == 6) ? 1'b1 : (g == 7) ? 1'b0 : gfd[g] ? ded[g % 4] : goe[g];
      check("oe_select", pin_oe[0], exp_b);
    end
    @(posedge clk_sys_i);
    ded <= '0;
    oesel[2:0] <= OE_ALWAYS_ON;
    oreg[0] <= 1'b1;
    alloc[0] <= 1'b1;
    casen[0] <= 1'b0;
    xs[1:0] <= XS_LOW;
    gbus[0] <= 1'b1;
    gbus[1] <= 1'b0;
    ext_val[1] <= 1'b1;
    pulse();
    check("pin_reg", pin_o[0], 1'b1);
    check("fb_pin_data", fb[1], 1'b1);
    check("oe_off_pin", pin_oe[1], 1'b0);
    @(posedge clk_sys_i);
    clrm[1:0] <= CS_GLOBAL;
    gclr[1:0] <= 2'h1;
    ded[1] <= 1'b1;
    @(negedge clk_sys_i);
    check("clear_now", pin_o[0], 1'b0);
    @(posedge clk_sys_i);
    ded[1] <= 1'b0;
    ceen[0] <= 1'b1;
    cept[2:0] <= 3'h1;
    pulse();
    check("ce_low", pin_o[0], 1'b0);
    @(posedge clk_sys_i);
    gbus[1] <= 1'b1;
    pulse();
    check("ce_high", pin_o[0], 1'b1);
    @(posedge clk_sys_i);
    gbus[0] <= 1'b0;
    preen[0] <= 1'b1;
    prept[2:0] <= 3'h2;
    ded[1] <= 1'b1;
    @(negedge clk_sys_i);
    check("clr_over_pre", pin_o[0], 1'b0);
    @(posedge clk_sys_i);
    ded[1] <= 1'b0;
    @(negedge clk_sys_i);
    check("preset", pin_o[0], 1'b1);
    @(posedge clk_sys_i);
    preen[0] <= 1'b0;
    smode[2:0] <= 3'(CMC_MODE_T);
    gbus[0] <= 1'b1;
    pulse();
    check("t_toggle_lo", pin_o[0], 1'b0);
    pulse();
    check("t_toggle_hi", pin_o[0], 1'b1);
    @(posedge clk_sys_i);
    smode[2:0] <= 3'(CMC_MODE_LATCH);
    ded[0] <= 1'b1;
    gbus[0] <= 1'b0;
    @(negedge clk_sys_i);
    check("latch_pass", pin_o[0], 1'b0);
    @(posedge clk_sys_i);
    ded[0] <= 1'b0;
    gbus[0] <= 1'b1;
    @(negedge clk_sys_i);
    check("latch_hold", pin_o[0], 1'b0);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    check("sig_rerst", sig, SIG_RESET);
    end_of_test();
  end
endmodule
